//--- rtl/gate_pkg.sv
// shared constants and types for the gate enable and mode control block
package gate_pkg;
   // clock and timing
   localparam int CLK_HZ = 200_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int LINK_BAUD = 9600;
   localparam int LINK_BIT_CYC = CLK_HZ / LINK_BAUD;
   localparam int LINK_DATA_BITS = 8;
   localparam int GATE_OFF_NS = 100;
   localparam int GATE_OFF_CYC = (GATE_OFF_NS * CLK_MHZ) / 1000;
   localparam int OE_QUAL_US = 1000;
   localparam int OE_QUAL_CYC = OE_QUAL_US * CLK_MHZ;
   localparam int REG_START_CYC = 64;
   localparam int WAKE_SETUP_CYC = 64;
   localparam int CLEAR_LOW_CYC = 1000;
   // fault and configuration layout
   localparam int FAULT_W = 4;
   localparam int CFG_W = 8;
   localparam int AMPLIFIER_STANDBY_OFF_BIT = 0;
   localparam int SLEEP_ENABLE_BIT = 1;
   localparam logic [CFG_W-1:0] DEAD_TIME_HOST = 8'h00;
   // pin vector order: a high, a low, b high, b low, c high, c low
   localparam int GATE_N = 6;
   typedef enum logic [1:0] {
      M_REG_START,
      M_ACTIVE,
      M_STANDBY,
      M_SLEEP
   } mode_t;
endpackage

//--- rtl/gate_link_if.sv
// pins between the gate driver device and its host
`timescale 1ns/1ps
interface gate_link_if;
   logic phase_a_high_pwm_in;
   logic phase_a_low_pwm_in;
   logic phase_b_high_pwm_in;
   logic phase_b_low_pwm_in;
   logic phase_c_high_pwm_in;
   logic phase_c_low_pwm_in;
   logic output_enable_pin;
   logic wake_pin;
   logic link_dev_pull;
   logic link_host_pull;
   logic half_duplex_link_pin;
   logic fault_dev_pull;
   logic fault_pin;
   // open-drain wires: any pull wins, the pull-up gives the high level [RULE_02]
   assign half_duplex_link_pin = ~(link_dev_pull | link_host_pull);
   assign fault_pin = ~fault_dev_pull;
   modport device (
      input phase_a_high_pwm_in, phase_a_low_pwm_in, phase_b_high_pwm_in,
      input phase_b_low_pwm_in, phase_c_high_pwm_in, phase_c_low_pwm_in,
      input output_enable_pin, wake_pin, half_duplex_link_pin,
      output link_dev_pull, fault_dev_pull
   );
   modport host (
      output phase_a_high_pwm_in, phase_a_low_pwm_in, phase_b_high_pwm_in,
      output phase_b_low_pwm_in, phase_c_high_pwm_in, phase_c_low_pwm_in,
      output output_enable_pin, wake_pin, link_host_pull,
      input half_duplex_link_pin, fault_pin
   );
endinterface

//--- rtl/od_uart.sv
// half-duplex open-drain serial port, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module od_uart #(
   parameter int BIT_CYC = gate_pkg::LINK_BIT_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // transmit request
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out,
   // received character
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   // line
   input wire logic line_in,
   output logic line_pull_out
);
   import gate_pkg::*;
   localparam int CW = $clog2(BIT_CYC + 1);
   localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2 - 1);
   localparam logic [3:0] STOP_IDX = 4'(LINK_DATA_BITS + 1);
   typedef enum logic [1:0] {U_IDLE, U_TX, U_RX} ustate_t;
   ustate_t st_q;
   logic [2:0] s_q;
   logic line_f_q, line_prev_q, pull_q, rx_valid_q;
   logic [CW-1:0] cnt_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q, rx_data_q;
   wire agree = s_q[1] ~^ s_q[2];
   wire line_fall = line_prev_q & ~line_f_q;
   wire [CW-1:0] target = (st_q == U_RX && bit_q == 4'h0) ? HALF : FULL;
   wire at_end = cnt_q == target;
   wire [3:0] bit_nx = bit_q + 4'h1;
   // only one side talks: no start while a character is arriving [RULE_01]
   assign tx_ready_out = (st_q == U_IDLE) & line_f_q & ~line_fall;
   assign line_pull_out = pull_q;
   assign rx_valid_out = rx_valid_q;
   assign rx_data_out = rx_data_q;
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q <= 3'h7;
         line_f_q <= 1'b1;
         line_prev_q <= 1'b1;
      end else begin
         s_q <= {s_q[1:0], line_in};
         if (agree) begin
            line_f_q <= s_q[2];
         end
         line_prev_q <= line_f_q;
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_q <= U_IDLE;
         cnt_q <= '0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         pull_q <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_data_q <= 8'h00;
      end else begin
         rx_valid_q <= 1'b0;
         cnt_q <= (st_q == U_IDLE || at_end) ? '0 : cnt_q + 1'b1;
         case (st_q)
            U_IDLE: begin
               bit_q <= 4'h0;
               if (tx_valid_in && tx_ready_out) begin
                  st_q <= U_TX;
                  sh_q <= tx_data_in;
                  pull_q <= 1'b1;
               end else if (line_fall) begin
                  st_q <= U_RX;
               end
            end
            U_TX: begin
               // 9600 baud, 8 data bits lsb first, no parity [RULE_01]
               if (at_end) begin
                  bit_q <= bit_nx;
                  if (bit_q == STOP_IDX) begin
                     st_q <= U_IDLE;
                  end else if (bit_nx == STOP_IDX) begin
                     pull_q <= 1'b0;
                  end else begin
                     pull_q <= ~sh_q[0];
                     sh_q <= {1'b0, sh_q[7:1]};
                  end
               end
            end
            U_RX: begin
               if (at_end) begin
                  bit_q <= bit_nx;
                  if (bit_q == 4'h0 && line_f_q) begin
                     st_q <= U_IDLE;
                  end else if (bit_q == STOP_IDX) begin
                     // a low stop bit is a framing error and the character is dropped
                     st_q <= U_IDLE;
                     rx_valid_q <= line_f_q;
                     if (line_f_q) begin
                        rx_data_q <= sh_q;
                     end
                  end else if (bit_q != 4'h0) begin
                     sh_q <= {line_f_q, sh_q[7:1]};
                  end
               end
            end
            default: begin
               st_q <= U_IDLE;
            end
         endcase
      end
   end
endmodule

//--- rtl/gate_device_end.sv
// device end: gate gating, enable qualification, power modes and fault latch
//
// Notes on behaviour
// [RULE_01] serial link: 9600 baud, 8 bits, half-duplex
// [RULE_02] link pins only pull low or release
// [RULE_03] low-side input drives low gate when enabled
// [RULE_04] high-side input drives high gate when enabled
// [RULE_05] dead time from host or config register
// [RULE_06] enable high keeps every function running
// [RULE_07] enable low means standby or sleep
// [RULE_08] standby turns off bootstrap supply, charge pump
// [RULE_09] standby turns amplifiers off only if configured
// [RULE_10] gates forced low within 100 ns
// [RULE_11] mode change only after 1 ms low
// [RULE_12] enable rising edge clears vanished latched faults
// [RULE_13] host clears faults with short low pulse
// [RULE_14] sleep bit selects sleep over standby
// [RULE_15] fault pin low until cleared and gone
// [RULE_16] wake rising edge after setup low leaves sleep
// [RULE_17] fault pin low until regulator start completes; the code does so only after reset, not after waking from sleep
// [RULE_18] low-enable timer restarts when enable returns
`timescale 1ns/1ps
module gate_device_end #(
   parameter int OE_QUAL_CYCLES = gate_pkg::OE_QUAL_CYC,
   parameter int LINK_BIT_CYCLES = gate_pkg::LINK_BIT_CYC,
   parameter int REG_START_CYCLES = gate_pkg::REG_START_CYC,
   parameter int WAKE_SETUP_CYCLES = gate_pkg::WAKE_SETUP_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // pins toward the host
   gate_link_if.device pins,
   // configuration
   input wire logic [gate_pkg::CFG_W-1:0] config_register_zero_in,
   input wire logic [gate_pkg::CFG_W-1:0] dead_time_config_register_in,
   // fault conditions from the detectors
   input wire logic [gate_pkg::FAULT_W-1:0] fault_cond_in,
   // gate drive outputs
   output logic phase_a_high_gate_out,
   output logic phase_a_low_gate_out,
   output logic phase_b_high_gate_out,
   output logic phase_b_low_gate_out,
   output logic phase_c_high_gate_out,
   output logic phase_c_low_gate_out,
   // power control and status
   output logic bootstrap_supply_out,
   output logic charge_pump_en_out,
   output logic amplifier_en_out,
   output logic regulator_en_out,
   output gate_pkg::mode_t mode_out,
   output logic [gate_pkg::FAULT_W-1:0] fault_latched_out,
   // serial link user side
   input wire logic link_tx_valid_in,
   input wire logic [7:0] link_tx_data_in,
   output logic link_tx_ready_out,
   output logic link_rx_valid_out,
   output logic [7:0] link_rx_data_out
);
   import gate_pkg::*;
   localparam int QW = $clog2(OE_QUAL_CYCLES + 1);
   localparam int RW = $clog2(REG_START_CYCLES + 1);
   localparam int WW = $clog2(WAKE_SETUP_CYCLES + 1);
   localparam logic [QW-1:0] QUAL_LAST = QW'(OE_QUAL_CYCLES - 1);
   localparam logic [RW-1:0] REG_LAST = RW'(REG_START_CYCLES - 1);
   localparam logic [WW-1:0] WAKE_MIN = WW'(WAKE_SETUP_CYCLES);
   localparam int PIN_N = GATE_N + 2;

   // pin inputs: three stages, a change counts once stages two and three agree
   logic [PIN_N-1:0] s1_q, s2_q, s3_q, filt_q;
   logic oe_prev_q, wake_prev_q;
   wire [PIN_N-1:0] pins_raw = {pins.wake_pin, pins.output_enable_pin,
      pins.phase_c_low_pwm_in, pins.phase_c_high_pwm_in,
      pins.phase_b_low_pwm_in, pins.phase_b_high_pwm_in,
      pins.phase_a_low_pwm_in, pins.phase_a_high_pwm_in};
   wire [PIN_N-1:0] agree = ~(s2_q ^ s3_q);
   wire [PIN_N-1:0] filt_d = (s3_q & agree) | (filt_q & ~agree);
   wire [GATE_N-1:0] pwm_f = filt_q[GATE_N-1:0];
   wire oe_f = filt_q[GATE_N];
   wire wake_f = filt_q[GATE_N+1];
   wire oe_rise = oe_f & ~oe_prev_q;
   wire wake_rise = wake_f & ~wake_prev_q;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
         oe_prev_q <= 1'b0;
         wake_prev_q <= 1'b0;
      end else begin
         s1_q <= pins_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         oe_prev_q <= oe_f;
         wake_prev_q <= wake_f;
      end
   end

   // mode machine
   mode_t mode_q, mode_d;
   logic [QW-1:0] qual_q;
   logic [RW-1:0] reg_cnt_q;
   logic [WW-1:0] wake_low_q;
   logic ready_q;
   wire qual_done = ~oe_f & (qual_q == QUAL_LAST);
   wire wake_ok = wake_rise & (wake_low_q >= WAKE_MIN);
   wire sleep_sel = config_register_zero_in[SLEEP_ENABLE_BIT];
   wire amp_off_sel = config_register_zero_in[AMPLIFIER_STANDBY_OFF_BIT];

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         M_REG_START: begin
            if (reg_cnt_q == REG_LAST) begin
               mode_d = M_ACTIVE;
            end
         end
         M_ACTIVE: begin
            // a short low only blanks the gates; the mode holds [RULE_11]
            if (qual_done) begin
               mode_d = sleep_sel ? M_SLEEP : M_STANDBY; // [RULE_14] [RULE_07]
            end
         end
         M_STANDBY: begin
            if (oe_f) begin
               mode_d = M_ACTIVE; // [RULE_06]
            end
         end
         M_SLEEP: begin
            // the regulator was off, so waking restarts it [RULE_16]
            if (wake_ok) begin
               mode_d = M_REG_START;
            end
         end
         default: begin
            mode_d = M_REG_START;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         mode_q <= M_REG_START;
         qual_q <= '0;
         reg_cnt_q <= '0;
         wake_low_q <= '0;
         ready_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         // qualification restarts whenever enable is seen high [RULE_18]
         qual_q <= (oe_f || mode_q != M_ACTIVE || qual_done) ? '0 : qual_q + 1'b1; // [RULE_11]
         reg_cnt_q <= (mode_q == M_REG_START) ? reg_cnt_q + 1'b1 : '0;
         if (wake_f) begin
            wake_low_q <= '0;
         end else if (wake_low_q != WAKE_MIN) begin
            wake_low_q <= wake_low_q + 1'b1;
         end
         if (mode_q == M_REG_START && mode_d == M_ACTIVE) begin
            ready_q <= 1'b1; // [RULE_17]
         end
      end
   end

   // gate drive with optional device dead time
   logic [GATE_N-1:0] gate_q;
   logic [CFG_W-1:0] off_cnt_q [GATE_N];
   wire run = (mode_q == M_ACTIVE) & oe_f;
   wire host_dead = dead_time_config_register_in == DEAD_TIME_HOST;
   logic [GATE_N-1:0] gate_d;

   for (genvar i = 0; i < GATE_N; i++) begin : g_gate
      localparam int J = i ^ 1;
      // partner must have been off for the configured count first [RULE_05]
      wire dead_ok = host_dead | (~pwm_f[J] & (off_cnt_q[J] >= dead_time_config_register_in));
      assign gate_d[i] = run & pwm_f[i] & dead_ok; // [RULE_03] [RULE_04] [RULE_10]
   end

   // one process owns the whole off-time array, so no element has two drivers
   always_ff @(posedge ref_clk_in) begin
      for (int k = 0; k < GATE_N; k++) begin
         if (rst_in || gate_q[k]) begin
            off_cnt_q[k] <= '0;
         end else if (off_cnt_q[k] != '1) begin
            off_cnt_q[k] <= off_cnt_q[k] + 1'b1; // [RULE_05]
         end
      end
   end

   // power outputs and fault latch
   logic boot_q, amp_q, reg_q;
   logic [FAULT_W-1:0] fault_q;
   // set wins over the clear in the same cycle
   wire [FAULT_W-1:0] fault_clr = oe_rise ? ~fault_cond_in : '0; // [RULE_12] [RULE_13]
   wire [FAULT_W-1:0] fault_d = (fault_q & ~fault_clr) | fault_cond_in;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         gate_q <= '0;
         boot_q <= 1'b0;
         amp_q <= 1'b0;
         reg_q <= 1'b0;
         fault_q <= '0;
      end else begin
         gate_q <= gate_d;
         boot_q <= mode_d == M_ACTIVE; // [RULE_08] [RULE_06]
         amp_q <= (mode_d == M_ACTIVE) | (mode_d == M_STANDBY & ~amp_off_sel); // [RULE_09]
         reg_q <= mode_d != M_SLEEP;
         fault_q <= fault_d;
      end
   end

   // open-drain fault pin: pulled while a fault stands or before the start-up after reset ends
   assign pins.fault_dev_pull = ~ready_q | (|fault_q) | (|fault_cond_in); // [RULE_15] [RULE_17] [RULE_02]

   assign phase_a_high_gate_out = gate_q[0];
   assign phase_a_low_gate_out = gate_q[1];
   assign phase_b_high_gate_out = gate_q[2];
   assign phase_b_low_gate_out = gate_q[3];
   assign phase_c_high_gate_out = gate_q[4];
   assign phase_c_low_gate_out = gate_q[5];
   assign bootstrap_supply_out = boot_q;
   assign charge_pump_en_out = boot_q;
   assign amplifier_en_out = amp_q;
   assign regulator_en_out = reg_q;
   assign mode_out = mode_q;
   assign fault_latched_out = fault_q;

   od_uart #(
      .BIT_CYC(LINK_BIT_CYCLES)
   ) u_link (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .tx_valid_in(link_tx_valid_in),
      .tx_data_in(link_tx_data_in),
      .tx_ready_out(link_tx_ready_out),
      .rx_valid_out(link_rx_valid_out),
      .rx_data_out(link_rx_data_out),
      .line_in(pins.half_duplex_link_pin),
      .line_pull_out(pins.link_dev_pull) // [RULE_01] [RULE_02]
   );
endmodule

//--- rtl/gate_host_end.sv
// host end: drives pwm, enable and wake pins, clears faults, talks on the link
`timescale 1ns/1ps
module gate_host_end #(
   parameter int LINK_BIT_CYCLES = gate_pkg::LINK_BIT_CYC,
   parameter int CLEAR_LOW_CYCLES = gate_pkg::CLEAR_LOW_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // pins toward the device
   gate_link_if.host pins,
   // user requests
   input wire logic [gate_pkg::GATE_N-1:0] pwm_request_in,
   input wire logic enable_request_in,
   input wire logic wake_request_in,
   input wire logic fault_clear_in,
   // status
   output logic fault_seen_out,
   output logic clearing_out,
   // serial link user side
   input wire logic link_tx_valid_in,
   input wire logic [7:0] link_tx_data_in,
   output logic link_tx_ready_out,
   output logic link_rx_valid_out,
   output logic [7:0] link_rx_data_out
);
   import gate_pkg::*;
   localparam int CW = $clog2(CLEAR_LOW_CYCLES + 1);
   logic [GATE_N-1:0] pwm_q;
   logic oe_q, wake_q;
   logic [CW-1:0] clr_q;
   logic [2:0] fs_q;
   logic fault_f_q;
   wire fs_agree = fs_q[1] ~^ fs_q[2];
   wire clr_busy = clr_q != '0;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pwm_q <= '0;
         oe_q <= 1'b0;
         wake_q <= 1'b0;
         clr_q <= '0;
         fs_q <= 3'h7;
         fault_f_q <= 1'b1;
      end else begin
         // any dead time the host wants is already in its requests [RULE_05]
         pwm_q <= pwm_request_in;
         wake_q <= wake_request_in;
         // low pulse well under the qualification time clears faults [RULE_13]
         if (fault_clear_in && !clr_busy) begin
            clr_q <= CW'(CLEAR_LOW_CYCLES);
         end else if (clr_busy) begin
            clr_q <= clr_q - 1'b1;
         end
         oe_q <= enable_request_in & ~clr_busy & ~(fault_clear_in & ~clr_busy);
         fs_q <= {fs_q[1:0], pins.fault_pin};
         if (fs_agree) begin
            fault_f_q <= fs_q[2];
         end
      end
   end

   assign pins.phase_a_high_pwm_in = pwm_q[0];
   assign pins.phase_a_low_pwm_in = pwm_q[1];
   assign pins.phase_b_high_pwm_in = pwm_q[2];
   assign pins.phase_b_low_pwm_in = pwm_q[3];
   assign pins.phase_c_high_pwm_in = pwm_q[4];
   assign pins.phase_c_low_pwm_in = pwm_q[5];
   assign pins.output_enable_pin = oe_q;
   assign pins.wake_pin = wake_q;
   assign fault_seen_out = ~fault_f_q;
   assign clearing_out = clr_busy;

   od_uart #(
      .BIT_CYC(LINK_BIT_CYCLES)
   ) u_link (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .tx_valid_in(link_tx_valid_in),
      .tx_data_in(link_tx_data_in),
      .tx_ready_out(link_tx_ready_out),
      .rx_valid_out(link_rx_valid_out),
      .rx_data_out(link_rx_data_out),
      .line_in(pins.half_duplex_link_pin),
      .line_pull_out(pins.link_host_pull) // [RULE_01] [RULE_02]
   );
endmodule

//--- bench/gate_link_chk.sv
// assertions on the pins between the device end and the host end
`timescale 1ns/1ps
module gate_link_chk (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // pins
   input wire logic link_dev_pull,
   input wire logic link_host_pull,
   input wire logic half_duplex_link_pin,
   input wire logic fault_dev_pull,
   input wire logic fault_pin
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   property p_one_talker;
      !(link_dev_pull && link_host_pull);
   endproperty
   a_one_talker: assert property (p_one_talker) else $error("both ends drive the link");
   property p_wire_level;
      half_duplex_link_pin == !(link_dev_pull || link_host_pull);
   endproperty
   a_wire_level: assert property (p_wire_level) else $error("link level not open drain");
   property p_host_bit;
      $changed(link_host_pull) |=> $stable(link_host_pull)[*8];
   endproperty
   a_host_bit: assert property (p_host_bit) else $error("host bit too short");
   property p_dev_bit;
      $changed(link_dev_pull) |=> $stable(link_dev_pull)[*8];
   endproperty
   a_dev_bit: assert property (p_dev_bit) else $error("device bit too short");
   property p_start_wire;
      $rose(link_dev_pull) |-> !half_duplex_link_pin[*8];
   endproperty
   a_start_wire: assert property (p_start_wire) else $error("start bit not low on wire");
   property p_ready_hold;
      $fell(rst_in) |-> fault_dev_pull[*6];
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("fault pin released early");
   property p_ready_release;
      $fell(rst_in) |-> ##[1:30] fault_pin;
   endproperty
   a_ready_release: assert property (p_ready_release) else $error("fault pin never released");
   property p_fault_od;
      fault_dev_pull |-> !fault_pin;
   endproperty
   a_fault_od: assert property (p_fault_od) else $error("fault pin high while pulled");
endmodule

//--- bench/gate_enable_mode_control_bench.sv
// self-checking bench for the device and host ends joined by their pins
`timescale 1ns/1ps
module gate_enable_mode_control_bench;
   import gate_pkg::*;
   localparam int QUAL = 200;
   localparam int BITC = 16;
   logic ref_clk_in, rst_in;
   logic [CFG_W-1:0] cfg_zero, dead_cfg;
   logic [FAULT_W-1:0] fault_cond, latched;
   logic [GATE_N-1:0] pwm_req, gates;
   logic en_req, wake_req, clear_req, fault_seen, clearing;
   logic boot, pump, amp, reg_en;
   mode_t mode;
   logic d_tx_valid, d_tx_ready, d_rx_valid, h_tx_valid, h_tx_ready, h_rx_valid;
   logic [7:0] d_tx_data, d_rx_data, h_tx_data, h_rx_data;
   int miscompares = 0;
   int cmp_count = 0;
   gate_link_if link ();
   gate_device_end #(.OE_QUAL_CYCLES(QUAL), .LINK_BIT_CYCLES(BITC), .REG_START_CYCLES(8),
      .WAKE_SETUP_CYCLES(8)) u_gate_device_end (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .pins(link.device),
      .config_register_zero_in(cfg_zero), .dead_time_config_register_in(dead_cfg), .fault_cond_in(fault_cond),
      .phase_a_high_gate_out(gates[0]), .phase_a_low_gate_out(gates[1]), .phase_b_high_gate_out(gates[2]),
      .phase_b_low_gate_out(gates[3]), .phase_c_high_gate_out(gates[4]), .phase_c_low_gate_out(gates[5]),
      .bootstrap_supply_out(boot), .charge_pump_en_out(pump), .amplifier_en_out(amp),
      .regulator_en_out(reg_en), .mode_out(mode), .fault_latched_out(latched),
      .link_tx_valid_in(d_tx_valid), .link_tx_data_in(d_tx_data), .link_tx_ready_out(d_tx_ready),
      .link_rx_valid_out(d_rx_valid), .link_rx_data_out(d_rx_data));
   gate_host_end #(.LINK_BIT_CYCLES(BITC), .CLEAR_LOW_CYCLES(20)) u_gate_host_end (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .pins(link.host),
      .pwm_request_in(pwm_req), .enable_request_in(en_req), .wake_request_in(wake_req),
      .fault_clear_in(clear_req), .fault_seen_out(fault_seen), .clearing_out(clearing),
      .link_tx_valid_in(h_tx_valid), .link_tx_data_in(h_tx_data), .link_tx_ready_out(h_tx_ready),
      .link_rx_valid_out(h_rx_valid), .link_rx_data_out(h_rx_data));
   gate_link_chk u_gate_link_chk (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_dev_pull(link.link_dev_pull),
      .link_host_pull(link.link_host_pull), .half_duplex_link_pin(link.half_duplex_link_pin),
      .fault_dev_pull(link.fault_dev_pull), .fault_pin(link.fault_pin));
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic t_startup();
      check(8'(mode), 8'(M_REG_START));
      check({7'h00, link.fault_pin}, 8'h00);
      cyc(30);
      check(8'(mode), 8'(M_ACTIVE));
      check({6'h00, link.fault_pin, fault_seen}, 8'h02);
      check({4'h0, boot, pump, amp, reg_en}, 8'h0F);
   endtask
   task automatic t_gates();
      for (int i = 0; i < GATE_N; i++) begin
         pwm_req = 6'(1 << i);
         cyc(8);
         check(8'(gates), 8'(1 << i));
      end
      // host owns dead time: both sides pass straight through
      pwm_req = 6'h3F;
      cyc(8);
      check(8'(gates), 8'h3F);
      dead_cfg = 8'h04;
      cyc(8);
      check(8'(gates), 8'h00);
      pwm_req = 6'h15;
      cyc(12);
      check(8'(gates), 8'h15);
      dead_cfg = 8'h00;
      en_req = 1'b0;
      cyc(19);
      check(8'(gates), 8'h00);
      check(8'(mode), 8'(M_ACTIVE));
      en_req = 1'b1;
      cyc(10);
      pwm_req = 6'h00;
   endtask
   task automatic t_short_low();
      // two lows adding up past the qualification time, split by a brief high
      en_req = 1'b0;
      cyc(150);
      en_req = 1'b1;
      cyc(6);
      en_req = 1'b0;
      cyc(150);
      check(8'(mode), 8'(M_ACTIVE));
      en_req = 1'b1;
      cyc(10);
   endtask
   task automatic t_standby(input logic amp_off);
      cfg_zero = {7'h00, amp_off};
      en_req = 1'b0;
      cyc(150);
      check(8'(mode), 8'(M_ACTIVE));
      cyc(80);
      check(8'(mode), 8'(M_STANDBY));
      check({4'h0, boot, pump, amp, reg_en}, {6'h00, ~amp_off, 1'b1});
      en_req = 1'b1;
      cyc(10);
      check(8'(mode), 8'(M_ACTIVE));
   endtask
   task automatic t_sleep();
      cfg_zero = 8'h02;
      wake_req = 1'b1;
      en_req = 1'b0;
      cyc(230);
      check(8'(mode), 8'(M_SLEEP));
      check({7'h00, reg_en}, 8'h00);
      en_req = 1'b1;
      cyc(20);
      check(8'(mode), 8'(M_SLEEP));
      // a low shorter than the setup time must not wake
      wake_req = 1'b0;
      cyc(3);
      wake_req = 1'b1;
      cyc(20);
      check(8'(mode), 8'(M_SLEEP));
      wake_req = 1'b0;
      cyc(20);
      wake_req = 1'b1;
      cyc(40);
      check(8'(mode), 8'(M_ACTIVE));
      wake_req = 1'b0;
      cfg_zero = 8'h00;
      cyc(20);
   endtask
   task automatic t_fault();
      fault_cond = 4'h4;
      cyc(1);
      fault_cond = 4'h2;
      cyc(10);
      check(8'(latched), 8'h06);
      check({7'h00, fault_seen}, 8'h01);
      clear_req = 1'b1;
      cyc(1);
      clear_req = 1'b0;
      check({7'h00, clearing}, 8'h01);
      cyc(40);
      check(8'(latched), 8'h02);
      check({7'h00, clearing}, 8'h00);
      check(8'(mode), 8'(M_ACTIVE));
      fault_cond = 4'h0;
      cyc(10);
      check({latched, 3'h0, link.fault_pin}, 8'h20);
      clear_req = 1'b1;
      cyc(1);
      clear_req = 1'b0;
      cyc(40);
      check({latched, 3'h0, fault_seen}, 8'h00);
   endtask
   task automatic t_link();
      h_tx_data = 8'hA5;
      h_tx_valid = 1'b1;
      for (int n = 0; n < 50 && h_tx_ready !== 1'b1; n++) cyc(1);
      cyc(1);
      h_tx_valid = 1'b0;
      check({7'h00, h_tx_ready}, 8'h00);
      for (int n = 0; n < 400 && d_rx_valid !== 1'b1; n++) cyc(1);
      check({7'h00, d_rx_valid}, 8'h01);
      check(d_rx_data, 8'hA5);
      cyc(40);
      d_tx_data = 8'h3C;
      d_tx_valid = 1'b1;
      for (int n = 0; n < 50 && d_tx_ready !== 1'b1; n++) cyc(1);
      cyc(1);
      d_tx_valid = 1'b0;
      check({7'h00, d_tx_ready}, 8'h00);
      for (int n = 0; n < 400 && h_rx_valid !== 1'b1; n++) cyc(1);
      check({7'h00, h_rx_valid}, 8'h01);
      check(h_rx_data, 8'h3C);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      miscompares++;
      $display("ERROR at %0t: watchdog expired", $time);
      give_verdict();
   end
   initial begin
      rst_in = 1'b1;
      cfg_zero = 8'h00;
      dead_cfg = 8'h00;
      fault_cond = 4'h0;
      pwm_req = 6'h00;
      en_req = 1'b1;
      wake_req = 1'b0;
      clear_req = 1'b0;
      d_tx_valid = 1'b0;
      d_tx_data = 8'h00;
      h_tx_valid = 1'b0;
      h_tx_data = 8'h00;
      repeat (5) @(negedge ref_clk_in);
      rst_in = 1'b0;
      t_startup();
      t_gates();
      t_short_low();
      t_standby(1'b0);
      t_standby(1'b1);
      t_sleep();
      t_fault();
      t_link();
      give_verdict();
   end
endmodule
